/* core/rscb_defs.svh */
// Constants for the relay switch control bank: offsets, reset values,
// timing figures. Assumes a 50 MHz core clock.
`ifndef RSCB_DEFS_SVH
`define RSCB_DEFS_SVH

`define RSCB_OFS_BANK_LOW     8'h01
`define RSCB_OFS_BANK_MID     8'h03
`define RSCB_OFS_BANK_HIGH    8'h05
`define RSCB_BANK_RESET       8'h00
`define RSCB_HIGH_USED_MASK   8'h0f
`define RSCB_CLK_PERIOD_NS    20
`define RSCB_QUAL_TIME_NS     500
// Strictly longer than 500 ns: one cycle more than the rounded-up count
`define RSCB_QUAL_CYCLES \
  (((`RSCB_QUAL_TIME_NS + `RSCB_CLK_PERIOD_NS - 1) / `RSCB_CLK_PERIOD_NS) + 1)

`endif

/* core/rscb_estop_qual.sv */
// Emergency input qualifier: synchroniser, polarity select, counter.
// Assumes the contact input is asynchronous to clk.
`timescale 1ns/100ps
`include "rscb_defs.svh"
`default_nettype none

module rscb_estop_qual #(
  parameter int QUAL_CYCLES = `RSCB_QUAL_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic contact_closed,
  input  wire logic contact_polarity_jumper,
  output var  logic estop_active
);

  logic                    sync1_reg;
  logic                    sync2_reg;
  logic [15:0]             cnt_reg;
  rscb_pkg::rscb_state_t   state_reg;
  rscb_pkg::rscb_state_t   state_next;
  logic                    tripped;
  logic                    expired;

  // Jumper absent: closed contact is the emergency; fitted: open contact
  assign tripped = contact_polarity_jumper ? ~sync2_reg : sync2_reg;
  assign expired = (cnt_reg >= 16'(QUAL_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= contact_closed;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    case (state_reg)
      rscb_pkg::RSCB_IDLE:   state_next = tripped ? rscb_pkg::RSCB_COUNT
                                                  : rscb_pkg::RSCB_IDLE;
      rscb_pkg::RSCB_COUNT:  state_next = !tripped ? rscb_pkg::RSCB_IDLE
                                        : expired ? rscb_pkg::RSCB_ACTIVE
                                                  : rscb_pkg::RSCB_COUNT;
      rscb_pkg::RSCB_ACTIVE: state_next = tripped ? rscb_pkg::RSCB_ACTIVE
                                                  : rscb_pkg::RSCB_IDLE;
      default:               state_next = rscb_pkg::RSCB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= rscb_pkg::RSCB_IDLE;
      cnt_reg   <= 16'h0000;
    end else if (ce) begin
      state_reg <= state_next;
      // Counter restarts on any return to the normal level
      cnt_reg   <= (state_next == rscb_pkg::RSCB_COUNT &&
                    state_reg == rscb_pkg::RSCB_COUNT) ? cnt_reg + 16'h0001
                                                       : 16'h0000;
    end
  end

  assign estop_active = (state_reg == rscb_pkg::RSCB_ACTIVE);

endmodule // rscb_estop_qual

`default_nettype wire

/* core/rscb_pkg.sv */
// Types for the relay switch control bank.
// Assumes nothing of its surroundings.
`default_nettype none

package rscb_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } rscb_req_t;

  typedef enum logic [1:0] {
    RSCB_IDLE   = 2'b00,
    RSCB_COUNT  = 2'b01,
    RSCB_ACTIVE = 2'b11
  } rscb_state_t;

endpackage

`default_nettype wire

/* core/rscb_relay_bank.sv */
// Relay switch control bank: three byte-wide relay control registers,
// inverted read-back, emergency open with local or global scope.
// Assumes synchronous byte accesses on a 10-bit module window offset.
//
// Overview of operation
// - Register k bit b drives channel 8k+b
// - Written one closes relay, zero opens
// - Reads return one's complement of written value
// - Emergency opens all relays by hardware
// - Relays stay open after emergency clears
// - Normally-open: closed over 500 ns trips
// - Normally-closed (jumper fitted): open over 500 ns
// - No polarity jumper means normally-open
// - Scope jumper fitted: propagate reset globally
// - No scope jumper: reset only this module
// - Ignore commands while emergency stays active
// - Accept commands again after emergency clears
// - One write updates its channels together
// - Registers at offsets one, three, five
`timescale 1ns/100ps
`include "rscb_defs.svh"
`default_nettype none

module rscb_relay_bank #(
  parameter int CHANNELS    = 20,
  parameter int QUAL_CYCLES = `RSCB_QUAL_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire rscb_pkg::rscb_req_t   req,
  output var  logic [7:0]            rdata,
  output var  logic                  rdata_valid,
  input  wire logic                  contact_closed,
  input  wire logic                  contact_polarity_jumper,
  input  wire logic                  reset_scope_jumper,
  input  wire logic                  global_reset_in,
  output var  logic                  global_reset_out,
  output var  logic [CHANNELS-1:0]   relay_close
);

  function automatic logic [1:0] bank_sel(input logic [9:0] a);
    case (a[7:0])
      `RSCB_OFS_BANK_LOW:  bank_sel = 2'd0;
      `RSCB_OFS_BANK_MID:  bank_sel = 2'd1;
      `RSCB_OFS_BANK_HIGH: bank_sel = 2'd2;
      default:             bank_sel = 2'd3;
    endcase
  endfunction

  logic [7:0]  relay_bank_low_reg;
  logic [7:0]  relay_bank_mid_reg;
  logic [7:0]  relay_bank_high_reg;
  logic [7:0]  rdata_next;
  logic [1:0]  sel;
  logic        hit;
  logic        estop_local;
  logic        estop_any;
  logic        wr_ok;

  rscb_estop_qual #(
    .QUAL_CYCLES (QUAL_CYCLES)
  ) u_qual (
    .clk                     (clk),
    .rst                     (rst),
    .ce                      (ce),
    .contact_closed          (contact_closed),
    .contact_polarity_jumper (contact_polarity_jumper),
    .estop_active            (estop_local)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode and emergency scope

  assign sel = bank_sel(req.addr);
  assign hit = (req.addr[9:8] == 2'b00) && (sel != 2'd3);
  // Global bus reset from other modules always acts; ours drives it only
  // when the scope jumper is fitted
  assign global_reset_out = estop_local & reset_scope_jumper;
  assign estop_any = estop_local | global_reset_in;
  assign wr_ok = req.wr & hit & ~estop_any;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk) begin
    if (rst) begin
      relay_bank_low_reg  <= `RSCB_BANK_RESET;
      relay_bank_mid_reg  <= `RSCB_BANK_RESET;
      relay_bank_high_reg <= `RSCB_BANK_RESET;
    end else if (ce) begin
      if (estop_any) begin
        // Cleared, so relays stay open after release
        relay_bank_low_reg  <= `RSCB_BANK_RESET;
        relay_bank_mid_reg  <= `RSCB_BANK_RESET;
        relay_bank_high_reg <= `RSCB_BANK_RESET;
      end else if (wr_ok) begin
        // Whole byte written at once
        case (sel)
          2'd0:    relay_bank_low_reg  <= req.wdata;
          2'd1:    relay_bank_mid_reg  <= req.wdata;
          2'd2:    relay_bank_high_reg <= req.wdata;
          default: relay_bank_low_reg  <= relay_bank_low_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-back, inverted

  always_comb begin
    case (sel)
      2'd0:    rdata_next = ~relay_bank_low_reg;
      2'd1:    rdata_next = ~relay_bank_mid_reg;
      2'd2:    rdata_next = ~relay_bank_high_reg;
      default: rdata_next = 8'hff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end else if (ce) begin
      rdata_valid <= req.rd & hit;
      if (req.rd & hit) begin
        rdata <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Relay drive, forced open by hardware during an emergency

  logic [23:0] bank_all;
  assign bank_all = {relay_bank_high_reg & `RSCB_HIGH_USED_MASK,
                     relay_bank_mid_reg, relay_bank_low_reg};
  assign relay_close = estop_any ? '0 : bank_all[CHANNELS-1:0];

endmodule // rscb_relay_bank

`default_nettype wire

/* sim/rscb_checker.sv */
// Port checker for the relay bank, bound into its top module.
// Assumes one clock domain; ce drops only while no trip is under way.
`timescale 1ns/100ps
`default_nettype none
module rscb_checker #(
  parameter int CHANNELS    = 20,
  parameter int QUAL_CYCLES = 26
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                ce,
  input wire rscb_pkg::rscb_req_t req,
  input wire logic [7:0]          rdata,
  input wire logic                rdata_valid,
  input wire logic                contact_closed,
  input wire logic                contact_polarity_jumper,
  input wire logic                reset_scope_jumper,
  input wire logic                global_reset_in,
  input wire logic                global_reset_out,
  input wire logic [CHANNELS-1:0] relay_close
);
  logic [3:0] quiet_cnt;
  logic [5:0] trip_cnt;
  wire        tripped = contact_closed ^ contact_polarity_jumper;
  wire        quiet   = quiet_cnt > 4'h6 && !global_reset_in;
  wire        long_trip = int'(trip_cnt) > QUAL_CYCLES + 5;
  always_ff @(posedge clk) begin
    if (rst || tripped || global_reset_in) quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
    if (rst || !tripped) trip_cnt <= 6'h0;
    else if (trip_cnt != 6'h3f) trip_cnt <= trip_cnt + 6'h1;
  end
  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [9:0] a);
    ce && req.wr && req.addr == a && quiet;
  endsequence
  a_write_low: assert property (s_wr(10'h001) |=>
    relay_close[7:0] == $past(req.wdata)) else $error("low bank");
  a_write_mid: assert property (s_wr(10'h003) |=>
    relay_close[15:8] == $past(req.wdata)) else $error("mid bank");
  a_write_high: assert property (s_wr(10'h005) |=>
    relay_close[19:16] == $past(req.wdata[3:0])) else $error("high");
  a_read_inverted: assert property (ce && req.rd && req.addr == 10'h003
    && quiet |=> rdata_valid && rdata == ~$past(relay_close[15:8]))
    else $error("read value");
  a_unmapped_read: assert property (ce && req.rd && req.addr == 10'h002
    |=> !rdata_valid) else $error("unmapped read answered");
  a_trip_opens: assert property (long_trip |-> relay_close == '0)
    else $error("relays not opened");
  a_scope_local: assert property (!reset_scope_jumper
    |-> !global_reset_out) else $error("local reset spread");
  a_scope_global: assert property (long_trip && reset_scope_jumper
    |-> global_reset_out) else $error("global reset missing");
  a_open_holds: assert property (!(ce && req.wr) && relay_close == '0
    |=> relay_close == '0) else $error("relay closed unasked");
  a_global_in: assert property (global_reset_in [*4]
    |-> relay_close == '0) else $error("global reset ignored");
endmodule // rscb_checker
bind rscb_relay_bank rscb_checker #(.CHANNELS(CHANNELS),
  .QUAL_CYCLES(QUAL_CYCLES)) u_rscb_checker (.clk(clk), .rst(rst),
  .ce(ce), .req(req), .rdata(rdata), .rdata_valid(rdata_valid),
  .contact_closed(contact_closed),
  .contact_polarity_jumper(contact_polarity_jumper),
  .reset_scope_jumper(reset_scope_jumper),
  .global_reset_in(global_reset_in),
  .global_reset_out(global_reset_out), .relay_close(relay_close));
`default_nettype wire

/* sim/rscb_safety_switch.sv */
// Safety switch model driving the bank's emergency contact input.
// Assumes the bench sets the press level away from the clock edge.
`timescale 1ns/100ps
`default_nettype none
module rscb_safety_switch (
  input  wire logic pressed,
  input  wire logic normally_closed,
  output var  logic contact_closed
);
  // Normally-open closes when pressed, normally-closed opens
  assign contact_closed = pressed ^ normally_closed;
endmodule // rscb_safety_switch
`default_nettype wire

/* sim/tb_relay_switch_control_bank.sv */
// Bench for the relay bank: byte accesses and emergency trips.
// Assumes the safety switch model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_relay_switch_control_bank;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  rscb_pkg::rscb_req_t req = '0;
  logic                pressed = 1'b0;
  logic                pol = 1'b0;
  logic                scope = 1'b0;
  logic                g_in = 1'b0;
  logic                ce = 1'b1;
  logic                contact, rdv, g_out;
  logic [7:0]          rdata;
  logic [19:0]         rc;
  int                  n_errors = 0;
  int                  num_checks = 0;
  always #10 clk = ~clk;
  rscb_safety_switch u_rscb_safety_switch (.pressed(pressed),
    .normally_closed(pol), .contact_closed(contact));
  rscb_relay_bank #(.QUAL_CYCLES(3)) u_rscb_relay_bank (.clk(clk),
    .rst(rst), .ce(ce), .req(req), .rdata(rdata), .rdata_valid(rdv),
    .contact_closed(contact), .contact_polarity_jumper(pol),
    .reset_scope_jumper(scope), .global_reset_in(g_in),
    .global_reset_out(g_out), .relay_close(rc));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [19:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk) req.wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk) req.rd = 1'b0;
    chk("rdata_valid", 20'(a[0]), 20'(rdv));
    if (a[0]) chk("rdata", 20'(e), 20'(rdata));
    @(negedge clk);
  endtask
  task automatic hold(input logic p, input int n);
    pressed = p;
    repeat (n) @(negedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd(10'h001, 8'hff);
    rd(10'h005, 8'hff);
    wr(10'h001, 8'h85);
    wr(10'h003, 8'h20);
    wr(10'h005, 8'hff);
    chk("relay_close", 20'hf2085, rc);
    rd(10'h005, 8'h00);
    rd(10'h002, 8'h00);
    wr(10'h004, 8'h00);
    wr(10'h005, ~8'h00 & ~8'h01);
    hold(1'b1, 2);
    hold(1'b0, 6);
    chk("relay_close", 20'he2085, rc);
    hold(1'b1, 12);
    wr(10'h001, 8'h01);
    chk("relay_close", 20'h0, rc);
    chk("global_reset_out", 20'h0, 20'(g_out));
    hold(1'b0, 8);
    chk("relay_close", 20'h0, rc);
    rd(10'h003, 8'hff);
    wr(10'h001, 8'h01);
    chk("relay_close", 20'h1, rc);
    ce = 1'b0;
    wr(10'h001, 8'h00);
    ce = 1'b1;
    chk("relay_close", 20'h1, rc);
    pol = 1'b1;
    scope = 1'b1;
    hold(1'b0, 8);
    chk("relay_close", 20'h1, rc);
    hold(1'b1, 12);
    chk("relay_close", 20'h0, rc);
    chk("global_reset_out", 20'h1, 20'(g_out));
    hold(1'b0, 8);
    wr(10'h003, 8'h01);
    g_in = 1'b1;
    repeat (6) @(negedge clk);
    chk("relay_close", 20'h0, rc);
    g_in = 1'b0;
    @(negedge clk);
    chk("relay_close", 20'h0, rc);
    wr(10'h001, 8'hff);
    chk("relay_close", 20'h000ff, rc);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("relay_close", 20'h0, rc);
    rd(10'h001, 8'hff);
    finish_test;
  end
  initial begin
    #100us;
    n_errors++;
    finish_test;
  end
endmodule // tb_relay_switch_control_bank
`default_nettype wire
